// ---- verilog/swpm_pkg.sv ----
// constants shared by the switch port power management register block
// Overview of operation
// - device specific init resets zero, lockable write
// - aux current field always reads zero
// - d1 and d2 support bits read zero
// - wake support field defaults to 11001 pattern
// - wake support writes change only advertisement
// - no wake forwarding while in d3cold
// - power state rw, d0=0 d3hot=3, reset 0
// - codes 1 and 2 reserved, never valid
// - context preserved bit defaults to one
// - wake enable gates message generation, sticky
// - hot reset keeps wake enable unchanged
// - own wake sets status, write one clears
// - relayed wake never sets status
// - upstream port never sets wake status
// - data select and scale read zero
// - top data byte reads zero
// - bus state and power control bits zero
package swpm_pkg;
   localparam logic [11:0] SWPM_CAP_ADDR = 12'h0c0;  // capabilities word
   localparam logic [11:0] SWPM_CSR_ADDR = 12'h0c4;  // control and status
   localparam logic [11:0] SWPM_IRQ_STAT_ADDR = 12'h100;  // event status, read only
   localparam logic [11:0] SWPM_IRQ_CLR_ADDR = 12'h104;  // event clear, write only
   localparam logic [11:0] SWPM_IRQ_EN_ADDR = 12'h108;  // event enable
   localparam int SWPM_DEVICE_SPECIFIC_INIT_BIT = 21;
   localparam int SWPM_WSUP_LSB = 27;
   localparam int SWPM_WSUP_MSB = 31;
   localparam int SWPM_PS_LSB = 0;  // power state field, low bit
   localparam int SWPM_PS_MSB = 1;  // power state field, high bit
   // bits that must read zero: aux current, d1/d2 and the lower fields kept elsewhere
   localparam logic [31:0] SWPM_CAP_ZERO_MASK = 32'h07df_ffff;
   // bits that must read zero: reserved, data select/scale, bus bits, data byte
   localparam logic [31:0] SWPM_CSR_ZERO_MASK = 32'hffff_7ef4;
   localparam int SWPM_CTX_BIT = 3;
   localparam int SWPM_WEN_BIT = 8;
   localparam int SWPM_WST_BIT = 15;
   localparam logic [4:0] SWPM_WSUP_RST = 5'h19;  // d0, d3hot, d3cold
   localparam logic [1:0] SWPM_PS_D0 = 2'h0;
   localparam logic [1:0] SWPM_PS_D3HOT = 2'h3;
   localparam int SWPM_IRQ_W = 3;  // own wake, relayed wake, state change
   localparam int SWPM_EV_OWN = 0;
   localparam int SWPM_EV_RELAY = 1;
   localparam int SWPM_EV_PS = 2;
endpackage

// ---- verilog/swpm_regs.sv ----
// switch port power management register bank
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module swpm_regs
   import swpm_pkg::*;
(
   input wire logic clock,
   input wire logic srst,  // fundamental reset
   input wire logic hot_rst,  // hot reset, spares sticky bits
   input wire logic clk_en,
   input wire logic is_upstream,  // port is the upstream port
   input wire logic lock_en,  // lockable fields writable (eeprom init)
   input wire logic in_d3cold,  // power removed, d3cold
   input wire logic own_wake,  // port itself raises a wake event
   input wire logic relay_wake,  // wake message from below to relay
   input wire logic [11:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   output logic [1:0] power_state,
   output logic context_preserved,
   output logic wake_msg,  // one-cycle request to send a wake message
   output logic irq
);
   // capability group: both fields lockable, restored by hot reset
   logic device_specific_init_q;  // device_specific_init
   logic device_specific_init_d;  // next device_specific_init
   logic [4:0] wsup_q;  // advertised wake support
   logic [4:0] wsup_d;  // next advertised wake support

   // control and status group
   logic [1:0] ps_q;  // power_state field
   logic [1:0] ps_d;  // next power_state
   logic ctx_q;  // context_preserved, lockable
   logic ctx_d;  // next context_preserved
   logic wen_q;  // wake_event_enable, sticky
   logic wen_d;  // next wake_event_enable
   logic wst_q;  // wake_event_status, sticky
   logic wst_d;  // next wake_event_status

   // event group behind the interrupt line
   logic [SWPM_IRQ_W-1:0] ist_q;  // sticky event status
   logic [SWPM_IRQ_W-1:0] ist_d;  // next event status
   logic [SWPM_IRQ_W-1:0] ien_q;  // event enable
   logic [SWPM_IRQ_W-1:0] ien_d;  // next event enable

   // next values of the registered outputs
   logic [31:0] rdata_d;  // read data, stands one cycle
   logic wake_d;  // next wake message request
   logic irq_d;  // next interrupt level

   // decoded write strobes; hot reset shadows all of them
   logic cap_wr;  // write to the capabilities word
   logic csr_wr;  // write to control and status
   logic clr_wr;  // write to the event clear register
   logic en_wr;  // write to the event enable register
   logic own_ok;  // own event that counts (not upstream)

   // capabilities word, fixed zero fields included
   function automatic logic [31:0] cap_word(input logic dv, input logic [4:0] ws);
      cap_word = '0;
      cap_word[SWPM_DEVICE_SPECIFIC_INIT_BIT] = dv;
      // aux current and d1/d2 stay zero
      cap_word[SWPM_WSUP_MSB:SWPM_WSUP_LSB] = ws;
   endfunction

   // write strobe for one register
   // a write that meets hot reset is dropped, so reset values win cleanly
   function automatic logic wr_hit(input logic w, input logic h, input logic [11:0] a, input logic [11:0] t);
      wr_hit = w & ~h & (a == t);
   endfunction

   // only d0 and d3hot are operating states; d1 and d2 codes are reserved
   function automatic logic ps_legal(input logic [1:0] code);
      ps_legal = (code == SWPM_PS_D0) || (code == SWPM_PS_D3HOT);
   endfunction

   // address decode, shared by the register groups below
   always_comb begin
      cap_wr = wr_hit(wr, hot_rst, addr, SWPM_CAP_ADDR);
      csr_wr = wr_hit(wr, hot_rst, addr, SWPM_CSR_ADDR);
      clr_wr = wr_hit(wr, hot_rst, addr, SWPM_IRQ_CLR_ADDR);
      en_wr = wr_hit(wr, hot_rst, addr, SWPM_IRQ_EN_ADDR);
      // the upstream port never originates a wake of its own
      own_ok = own_wake & ~is_upstream;
   end

   // capability group, next values
   always_comb begin
      device_specific_init_d = device_specific_init_q;
      wsup_d = wsup_q;
      if (hot_rst) begin
         // not sticky: back to defaults
         device_specific_init_d = 1'b0;
         wsup_d = SWPM_WSUP_RST;
      end else if (cap_wr && lock_en) begin
         // only the advertisement moves; generation never reads it
         device_specific_init_d = wdata[SWPM_DEVICE_SPECIFIC_INIT_BIT];
         wsup_d = wdata[SWPM_WSUP_MSB:SWPM_WSUP_LSB];
      end
   end

   // capability group, registers
   always_ff @(posedge clock) begin
      if (srst) begin
         device_specific_init_q <= 1'b0;
         wsup_q <= SWPM_WSUP_RST;
      end else if (clk_en) begin
         device_specific_init_q <= device_specific_init_d;
         wsup_q <= wsup_d;
      end
   end

   // control and status group, next values
   always_comb begin
      ps_d = ps_q;
      ctx_d = ctx_q;
      wen_d = wen_q;
      wst_d = wst_q;
      if (hot_rst) begin
         // non-sticky state returns to default
         ps_d = SWPM_PS_D0;
         ctx_d = 1'b1;
         // wake enable and status untouched
      end else if (csr_wr) begin
         // a reserved code leaves the state alone, other bits still land
         if (ps_legal(wdata[SWPM_PS_MSB:SWPM_PS_LSB]))
            ps_d = wdata[SWPM_PS_MSB:SWPM_PS_LSB];
         // context bit is lockable like the capability fields
         if (lock_en)
            ctx_d = wdata[SWPM_CTX_BIT];
         wen_d = wdata[SWPM_WEN_BIT];
         // write one clears the status
         if (wdata[SWPM_WST_BIT])
            wst_d = 1'b0;
      end
      // set comes after the clear so an event in the clear cycle is kept
      // relayed wakes are not looked at here
      if (own_ok)
         wst_d = 1'b1;
   end

   // control and status group, registers
   // sticky bits only follow the fundamental reset
   always_ff @(posedge clock) begin
      if (srst) begin
         ps_q <= SWPM_PS_D0;
         ctx_q <= 1'b1;
         wen_q <= 1'b0;
         wst_q <= 1'b0;
      end else if (clk_en) begin
         ps_q <= ps_d;
         ctx_q <= ctx_d;
         wen_q <= wen_d;
         wst_q <= wst_d;
      end
   end

   // event group, next values; every set wins over a clear in the same cycle
   always_comb begin
      ist_d = ist_q;
      ien_d = ien_q;
      // write one clears
      if (clr_wr)
         ist_d = ist_q & ~wdata[SWPM_IRQ_W-1:0];
      if (en_wr)
         ien_d = wdata[SWPM_IRQ_W-1:0];
      // events, applied last
      if (own_ok)
         ist_d[SWPM_EV_OWN] = 1'b1;
      if (relay_wake)
         ist_d[SWPM_EV_RELAY] = 1'b1;
      // any accepted change of power state, hot reset included
      if (ps_d != ps_q)
         ist_d[SWPM_EV_PS] = 1'b1;
   end

   // event group, registers; survive hot reset
   always_ff @(posedge clock) begin
      if (srst) begin
         ist_q <= '0;
         ien_q <= '0;
      end else if (clk_en) begin
         ist_q <= ist_d;
         ien_q <= ien_d;
      end
   end

   // registered outputs, next values
   always_comb begin
      // generation follows fixed behaviour, not the advertised field
      // relayed messages pass whatever the enable says
      wake_d = ~in_d3cold & ((own_ok & wen_q) | relay_wake);
      // built from next status so the line matches the status register
      irq_d = |(ist_d & ien_d);
      rdata_d = '0;
      if (rd) begin
         case (addr)
            SWPM_CAP_ADDR: rdata_d = cap_word(device_specific_init_q, wsup_q);
            SWPM_CSR_ADDR: begin
               // data fields, bus bits and reserved read zero
               rdata_d[SWPM_PS_MSB:SWPM_PS_LSB] = ps_q;
               rdata_d[SWPM_CTX_BIT] = ctx_q;
               rdata_d[SWPM_WEN_BIT] = wen_q;
               rdata_d[SWPM_WST_BIT] = wst_q;
            end
            SWPM_IRQ_STAT_ADDR: rdata_d[SWPM_IRQ_W-1:0] = ist_q;
            SWPM_IRQ_EN_ADDR: rdata_d[SWPM_IRQ_W-1:0] = ien_q;
            // the clear register is write only
            default: rdata_d = '0;  // unmapped reads zero
         endcase
      end
   end

   // registered outputs
   // power_state mirrors ps_q; a second flop costs little and keeps the port off logic
   always_ff @(posedge clock) begin
      if (srst) begin
         rdata <= '0;
         wake_msg <= 1'b0;
         irq <= 1'b0;
         power_state <= SWPM_PS_D0;
         context_preserved <= 1'b1;
      end else if (clk_en) begin
         rdata <= rdata_d;
         wake_msg <= wake_d;
         irq <= irq_d;
         power_state <= ps_d;
         context_preserved <= ctx_d;
      end
   end

   // state register never holds a reserved code
   ps_valid_a: assert property (@(posedge clock) disable iff (srst)
      ps_legal(ps_q)) else $error("reserved power state held");
   // reserved code written: state stays
   ps_reserved_a: assert property (@(posedge clock) disable iff (srst)
      clk_en && csr_wr && !ps_legal(wdata[SWPM_PS_MSB:SWPM_PS_LSB])
      |=> $stable(ps_q)) else $error("reserved power state write took effect");
   // upstream port keeps status clear
   upstream_st_a: assert property (@(posedge clock) disable iff (srst)
      is_upstream && $stable(is_upstream) && !$past(wst_q) |-> !wst_q) else $error("upstream status set");
   // own wake on a port that is not upstream always recorded
   own_sets_a: assert property (@(posedge clock) disable iff (srst)
      clk_en && own_wake && !is_upstream |=> wst_q) else $error("own wake lost");
   // hot reset spares enable
   hot_keep_a: assert property (@(posedge clock) disable iff (srst)
      clk_en && hot_rst |=> wen_q == $past(wen_q)) else $error("hot reset changed enable");
   // nothing leaves in d3cold
   cold_quiet_a: assert property (@(posedge clock) disable iff (srst)
      clk_en && in_d3cold |=> !wake_msg) else $error("wake forwarded in d3cold");
   // no own message while disabled
   wake_gate_a: assert property (@(posedge clock) disable iff (srst)
      clk_en && !wen_q && !relay_wake |=> !wake_msg) else $error("wake sent while disabled");
   // enabled own wake does leave
   wake_own_a: assert property (@(posedge clock) disable iff (srst)
      clk_en && own_ok && wen_q && !in_d3cold |=> wake_msg) else $error("enabled wake not sent");
   // unimplemented status fields read zero
   csr_zero_a: assert property (@(posedge clock) disable iff (srst)
      clk_en && rd && addr == SWPM_CSR_ADDR |=> (rdata & SWPM_CSR_ZERO_MASK) == '0)
      else $error("csr zero fields nonzero");
   // unimplemented capability fields read zero
   cap_zero_a: assert property (@(posedge clock) disable iff (srst)
      clk_en && rd && addr == SWPM_CAP_ADDR |=> (rdata & SWPM_CAP_ZERO_MASK) == '0)
      else $error("cap zero fields set");
   // relayed wake alone leaves status as it was
   relay_keep_a: assert property (@(posedge clock) disable iff (srst)
      clk_en && !own_ok && !csr_wr |=> $stable(wst_q)) else $error("status moved without own wake");
   // lockable fields frozen while locked
   lock_keep_a: assert property (@(posedge clock) disable iff (srst)
      clk_en && !hot_rst && !lock_en |=> $stable(device_specific_init_q) && $stable(wsup_q) && $stable(ctx_q))
      else $error("locked field changed");
   // write one with no event clears status
   wst_clear_a: assert property (@(posedge clock) disable iff (srst)
      clk_en && csr_wr && wdata[SWPM_WST_BIT] && !own_ok |=> !wst_q) else $error("status not cleared");
   // interrupt line follows enabled status
   irq_level_a: assert property (@(posedge clock) disable iff (srst)
      irq == |(ist_q & ien_q)) else $error("interrupt level wrong");
   // state port mirrors the field
   ps_port_a: assert property (@(posedge clock) disable iff (srst)
      power_state == ps_q) else $error("power state port differs");
endmodule  // swpm_regs

// ---- testbench/tb_top.sv ----
// self-checking bench for the switch port power management register bank
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_fail++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, got, exp); end end
module tb_top
   import swpm_pkg::*;
;
   logic clock = 0, srst = 1, hot_rst = 0, clk_en = 1, is_upstream = 0, lock_en = 0;
   logic in_d3cold = 0, own_wake = 0, relay_wake = 0, wr = 0, rd = 0;
   logic [11:0] addr = '0;
   logic [31:0] wdata = '0;
   logic [31:0] rdata;
   logic [1:0] power_state;
   logic context_preserved, wake_msg, irq;
   int n_fail = 0, total_checks = 0, cyc = 0;
   swpm_regs dut (.clock(clock), .srst(srst), .hot_rst(hot_rst), .clk_en(clk_en), .is_upstream(is_upstream),
      .lock_en(lock_en), .in_d3cold(in_d3cold), .own_wake(own_wake), .relay_wake(relay_wake), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .power_state(power_state),
      .context_preserved(context_preserved), .wake_msg(wake_msg), .irq(irq));
   // 25 ns period clock
   initial begin
      forever #12.5 clock = ~clock;
   end
   // one-cycle write strobe; takes effect at the edge that drops it
   task wr_reg(input logic [11:0] a, input logic [31:0] d);
      @(posedge clock) begin addr <= a; wdata <= d; wr <= 1'b1; end
      @(posedge clock) wr <= 1'b0;
   endtask
   // read strobe, then compare the masked data in the one cycle it stands
   task rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge clock) begin addr <= a; rd <= 1'b1; end
      @(posedge clock) rd <= 1'b0;
      #1;
      `CHK(rdata & m, e)
   endtask
   // one-cycle wake event pulse; wake_msg is sampled in the cycle after it
   task ev(input logic o, input logic r);
      @(posedge clock) begin own_wake <= o; relay_wake <= r; end
      @(posedge clock) begin own_wake <= 1'b0; relay_wake <= 1'b0; end
      #1;
   endtask
   // verdict, the only place the run ends
   task test_done;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // hang guard: the full sequence needs well under 300 cycles
   always @(posedge clock) begin
      cyc++;
      if (cyc > 2000) begin n_fail++; test_done(); end
   end
   initial begin
      repeat (8) @(posedge clock);
      srst <= 1'b0;
      rd_chk(SWPM_CAP_ADDR, 32'hc800_0000, 32'hffe0_0000);
      rd_chk(SWPM_CSR_ADDR, 32'h0000_0008, '1);
      // lockable fields refuse writes while locked
      wr_reg(SWPM_CAP_ADDR, 32'hffff_ffff);
      rd_chk(SWPM_CAP_ADDR, 32'hc800_0000, 32'hffe0_0000);
      wr_reg(SWPM_CSR_ADDR, 32'hffff_7fff);
      rd_chk(SWPM_CSR_ADDR, 32'h0000_010b, '1);
      `CHK(power_state, SWPM_PS_D3HOT)
      // reserved codes leave the state alone, other bits still land
      wr_reg(SWPM_CSR_ADDR, 32'h0000_0101);
      rd_chk(SWPM_CSR_ADDR, 32'h0000_010b, '1);
      wr_reg(SWPM_CSR_ADDR, 32'h0000_0002);
      rd_chk(SWPM_CSR_ADDR, 32'h0000_000b, '1);
      // unlocked: clear advertised wake support, set init bit, drop context bit
      lock_en <= 1'b1;
      wr_reg(SWPM_CAP_ADDR, 32'h0020_0000);
      wr_reg(SWPM_CSR_ADDR, 32'h0000_0103);
      lock_en <= 1'b0;
      rd_chk(SWPM_CAP_ADDR, 32'h0020_0000, 32'hffe0_0000);
      `CHK(context_preserved, 1'b0)
      // generation must not follow the edited advertisement
      ev(1'b1, 1'b0);
      `CHK(wake_msg, 1'b1)
      rd_chk(SWPM_CSR_ADDR, 32'h0000_8103, '1);
      // hot reset: sticky enable and status survive, the rest returns to default
      @(posedge clock) hot_rst <= 1'b1;
      @(posedge clock) hot_rst <= 1'b0;
      rd_chk(SWPM_CSR_ADDR, 32'h0000_8108, '1);
      rd_chk(SWPM_CAP_ADDR, 32'hc800_0000, 32'hffe0_0000);
      // write one clears status; enable written low in the same access
      wr_reg(SWPM_CSR_ADDR, 32'h0000_8000);
      rd_chk(SWPM_CSR_ADDR, 32'h0000_0008, '1);
      ev(1'b1, 1'b0);
      `CHK(wake_msg, 1'b0)
      rd_chk(SWPM_CSR_ADDR, 32'h0000_8008, '1);
      // nothing leaves in d3cold, own or relayed
      wr_reg(SWPM_CSR_ADDR, 32'h0000_8100);
      in_d3cold <= 1'b1;
      ev(1'b1, 1'b1);
      `CHK(wake_msg, 1'b0)
      @(posedge clock) in_d3cold <= 1'b0;
      wr_reg(SWPM_CSR_ADDR, 32'h0000_8100);
      ev(1'b0, 1'b1);
      `CHK(wake_msg, 1'b1)
      rd_chk(SWPM_CSR_ADDR, 32'h0000_0108, '1);
      // an upstream port never records its own wake
      @(posedge clock) is_upstream <= 1'b1;
      ev(1'b1, 1'b0);
      rd_chk(SWPM_CSR_ADDR, 32'h0000_0108, '1);
      @(posedge clock) is_upstream <= 1'b0;
      // interrupt: status sticky, masked until enabled, cleared by write one
      rd_chk(SWPM_IRQ_STAT_ADDR, 32'h0000_0003, 32'h0000_0003);
      `CHK(irq, 1'b0)
      wr_reg(SWPM_IRQ_EN_ADDR, 32'h0000_0001);
      rd_chk(SWPM_IRQ_EN_ADDR, 32'h0000_0001, 32'h0000_0007);
      `CHK(irq, 1'b1)
      wr_reg(SWPM_IRQ_CLR_ADDR, 32'h0000_0007);
      rd_chk(SWPM_IRQ_STAT_ADDR, 32'h0000_0000, 32'h0000_0007);
      `CHK(irq, 1'b0)
      rd_chk(12'h200, 32'h0000_0000, '1);
      test_done();
   end
endmodule  // tb_top
